/* File: shared/flash_read_pkg.sv */
// Purpose: constants, carriers and helpers of the serial flash read host
// Assumes: 10 MHz system clock, flash pins run in clock mode 0
// Notes: opcodes are plain defaults and may need changing for another part
package flash_read_pkg;
	// Register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] ADDR_OFS = 8'h04;
	localparam logic [7:0] STAT_OFS = 8'h08;
	localparam logic [7:0] DATA_OFS = 8'h0C;
	// Field positions
	localparam int CTRL_START      = 0;
	localparam int CTRL_MODE_LO    = 1;
	localparam int CTRL_WIDE       = 4;
	localparam int CTRL_QUAD_CMD   = 5;
	localparam int CTRL_DUMMY_LO   = 6;
	localparam int CTRL_QUAD_EN    = 8;
	localparam int CTRL_ABORT      = 9;
	localparam int CTRL_LEN_LO     = 16;
	localparam int STAT_BUSY       = 0;
	localparam int STAT_VALID      = 1;
	localparam int STAT_REFUSED    = 2;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// Read command kinds
	localparam logic [2:0] MODE_READ             = 3'h0;
	localparam logic [2:0] MODE_FAST_READ        = 3'h1;
	localparam logic [2:0] MODE_DUAL_OUTPUT_READ = 3'h2;
	localparam logic [2:0] MODE_DUAL_IO_READ     = 3'h3;
	localparam logic [2:0] MODE_QUAD_OUTPUT_READ = 3'h4;
	localparam logic [2:0] MODE_QUAD_IO_READ     = 3'h5;
	// Timing
	localparam int SYS_CLK_NS     = 100;
	localparam int SCLK_PERIOD_NS = 800;
	localparam int HALF_CYC       = SCLK_PERIOD_NS / (2 * SYS_CLK_NS);
	localparam int CS_HIGH_NS     = 400;
	localparam int CS_HIGH_CYC    = (CS_HIGH_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam int DIV_W          = 3;
	typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_DONE} st_type;
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_type;
	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_type;
	typedef struct packed {
		logic       cs_b;
		logic       sclk;
		logic [3:0] io_out;
		logic [3:0] io_oe;
	} pin_out_type;
	// Opcode of each read kind
	function automatic logic [7:0] opcode_of(input logic [2:0] m);
		case (m)
			MODE_FAST_READ:        opcode_of = 8'h0B;
			MODE_DUAL_OUTPUT_READ: opcode_of = 8'h3B;
			MODE_DUAL_IO_READ:     opcode_of = 8'hBB;
			MODE_QUAD_OUTPUT_READ: opcode_of = 8'h6B;
			MODE_QUAD_IO_READ:     opcode_of = 8'hEB;
			default:               opcode_of = 8'h03;
		endcase
	endfunction : opcode_of
	// Dummy clocks per kind and dummy code
	function automatic logic [5:0] dummy_clocks(input logic [2:0] m, input logic [1:0] dc);
		case (m)
			MODE_READ:         dummy_clocks = 6'd0;
			MODE_DUAL_IO_READ: dummy_clocks = dc[0] ? 6'd8 : 6'd4;
			MODE_QUAD_IO_READ: dummy_clocks = (dc == 2'd0) ? 6'd6 : (dc == 2'd1) ? 6'd4 : (dc == 2'd2) ? 6'd8 : 6'd10;
			default:           dummy_clocks = 6'd8;
		endcase
	endfunction : dummy_clocks
endpackage : flash_read_pkg

/* File: verilog/flash_read_host.sv */
// Purpose: host that issues the six serial flash read commands from APB orders
// Assumes: sys_clk 10 MHz; flash sclk made here by a divider
// Notes: one byte holding register, sclk pauses while it is unread
// Behaviour
// RQ1: Host changes lanes on sclk fall; data sampled before falling edge.
// RQ2: Flash streams from any address with auto-increment while selected.
// RQ3: Flash wraps its address to zero past the top location.
// RQ4: Three address bytes unless wide addressing is chosen.
// RQ5: Plain read: opcode and address on lane zero, data on lane one.
// RQ6: Host may raise chip select anywhere in data phase to end read.
// RQ7: Flash ignores reads while a program or erase cycle runs.
// RQ8: Fast read: eight default dummy clocks before data on lane one.
// RQ9: Flash takes dummy count from its two dummy code bits.
// RQ10: Dual output read: single-lane header, data two bits per clock.
// RQ11: Dual I/O read: address, four dummies and data on two lanes.
// RQ12: Quad reads only after the quad enable bit is set.
// RQ13: Quad output read: single-lane header, eight dummies, four-lane data.
// RQ14: Quad I/O read: address, six dummies and data on four lanes.
// RQ15: Flash accepts quad I/O read in single-line and quad command mode.
// RQ16: Host drives first two dummy clocks with a non-toggling pattern.
// RQ17: Wide addressing adds one address byte on the command's lanes; the host sends it on the address lanes (addr_w).
// RQ18: Flash keeps a wide address flag set and cleared by mode commands.
// RQ19: Most significant bit first, top lane carries the top bit.
// RQ20: Flash floats its lanes while deselected or not driving.
`timescale 1ns/10ps
module flash_read_host
	import flash_read_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	// Register bus
	input  apb_req_type      apb_req,
	output apb_rsp_type      apb_rsp,
	// Flash pins
	output pin_out_type      pins,
	input  wire logic [3:0]  io_in
);
	st_type            state_reg;
	logic [2:0]        mode_reg;
	logic              wide_addr_reg;
	logic              quad_cmd_reg;
	logic              quad_en_reg;
	logic [1:0]        dummy_code_reg;
	logic [15:0]       len_reg;
	logic [31:0]       addr_reg;
	logic              rx_valid_reg;
	logic              refused_reg;
	logic [7:0]        data_reg;
	logic [3:0]        io_meta_reg;
	logic [3:0]        io_sync_reg;
	logic [DIV_W-1:0]  div_reg;
	logic              sclk_reg;
	logic              cs_b_reg;
	logic [31:0]       out_sr_reg;
	logic [3:0]        io_out_reg;
	logic [3:0]        io_oe_reg;
	logic [2:0]        width_reg;
	logic [5:0]        clk_left_reg;
	logic [15:0]       byte_left_reg;
	logic [7:0]        rx_sr_reg;
	logic [3:0]        dummy_idx_reg;
	logic [5:0]        rise_cnt_reg;
	logic              wr;
	logic              rd;
	logic              ctrl_wr;
	logic              start_req;
	logic              abort_req;
	logic [2:0]        new_mode;
	logic              new_quad;
	logic              bad_start;
	logic              go;
	logic              busy;
	logic              active;
	logic              hdr;
	logic              run;
	logic              stall;
	logic              tick;
	logic              rise;
	logic              fall;
	logic              enter;
	logic              byte_done;
	logic [2:0]        addr_w;
	logic [2:0]        data_w;
	logic [5:0]        addr_n;
	logic [5:0]        dummy_n;
	logic [5:0]        per_byte;
	logic [7:0]        rx_next;
	st_type            tgt;
	logic [31:0]       ld_sr;
	logic [2:0]        ld_w;
	logic [5:0]        ld_cnt;
	logic [3:0]        ld_oe;
	logic [31:0]       sh_sr;

	// Lane mask for a lane count
	function automatic logic [3:0] lane_mask(input logic [2:0] w);
		lane_mask = (w == 3'd1) ? 4'h1 : (w == 3'd2) ? 4'h3 : 4'hF;
	endfunction : lane_mask

	// Top bits of the shifter onto the lanes, highest lane gets the top bit
	function automatic logic [3:0] lanes_of(input logic [31:0] sr, input logic [2:0] w);
		lanes_of = (w == 3'd1) ? {3'b000, sr[31]} : (w == 3'd2) ? {2'b00, sr[31:30]} : sr[31:28]; // RQ19
	endfunction : lanes_of

	// Bus decode; the slave always answers in the access cycle
	assign wr        = apb_req.psel && apb_req.penable && apb_req.pwrite;
	assign rd        = apb_req.psel && apb_req.penable && !apb_req.pwrite;
	assign ctrl_wr   = wr && (apb_req.paddr == CTRL_OFS);
	assign start_req = ctrl_wr && apb_req.pwdata[CTRL_START];
	assign abort_req = ctrl_wr && apb_req.pwdata[CTRL_ABORT];
	assign new_mode  = apb_req.pwdata[CTRL_MODE_LO +: 3];
	assign new_quad  = (new_mode == MODE_QUAD_OUTPUT_READ) || (new_mode == MODE_QUAD_IO_READ);
	// Quad kinds need the enable confirmed; quad command framing only for quad I/O
	assign bad_start = start_req && (busy || (new_mode > MODE_QUAD_IO_READ) ||
		(new_quad && !apb_req.pwdata[CTRL_QUAD_EN]) || // RQ12
		(apb_req.pwdata[CTRL_QUAD_CMD] && (new_mode != MODE_QUAD_IO_READ)));
	assign go        = start_req && !bad_start;
	assign busy      = (state_reg != ST_IDLE);
	assign active    = (state_reg == ST_CMD) || (state_reg == ST_ADDR) || (state_reg == ST_DUMMY) || (state_reg == ST_DATA);
	assign hdr       = (state_reg == ST_CMD) || (state_reg == ST_ADDR) || (state_reg == ST_DUMMY);

	// Per-kind lane counts and phase lengths
	assign addr_w   = (mode_reg == MODE_QUAD_IO_READ) ? 3'd4 : (mode_reg == MODE_DUAL_IO_READ) ? 3'd2 : 3'd1;
	assign data_w   = (mode_reg <= MODE_FAST_READ) ? 3'd1 :
		((mode_reg == MODE_DUAL_OUTPUT_READ) || (mode_reg == MODE_DUAL_IO_READ)) ? 3'd2 : 3'd4;
	assign addr_n   = (wide_addr_reg ? 6'd32 : 6'd24) >> ((addr_w == 3'd4) ? 2 : (addr_w == 3'd2) ? 1 : 0); // RQ4 RQ17
	assign dummy_n  = dummy_clocks(mode_reg, dummy_code_reg); // RQ8 RQ10 RQ11 RQ13 RQ14
	assign per_byte = (data_w == 3'd1) ? 6'd8 : (data_w == 3'd2) ? 6'd4 : 6'd2;

	// Divider: sclk pauses low at a byte start while the last byte is unread
	assign stall = (state_reg == ST_DATA) && rx_valid_reg && !sclk_reg && (clk_left_reg == per_byte);
	assign run   = active && !stall;
	assign tick  = run && (div_reg == DIV_W'(HALF_CYC - 1));
	assign rise  = tick && !sclk_reg;
	assign fall  = tick && sclk_reg;
	assign enter = (state_reg == ST_LOAD) || (hdr && fall && (clk_left_reg == 6'd1));
	assign byte_done = (state_reg == ST_DATA) && !abort_req && fall && (clk_left_reg == 6'd1);

	// Incoming bits; data on lane one for single-lane kinds
	assign rx_next = (width_reg == 3'd1) ? {rx_sr_reg[6:0], io_sync_reg[1]} : // RQ5
		(width_reg == 3'd2) ? {rx_sr_reg[5:0], io_sync_reg[1:0]} : {rx_sr_reg[3:0], io_sync_reg[3:0]};
	assign sh_sr   = out_sr_reg << width_reg;

	// Setup of the phase that follows the current one
	always_comb
	begin
		tgt    = ST_DATA;
		ld_sr  = 32'h0000_0000;
		ld_w   = data_w;
		ld_cnt = per_byte;
		ld_oe  = 4'h0;
		case (state_reg)
			ST_LOAD:  tgt = ST_CMD;
			ST_CMD:   tgt = ST_ADDR;
			ST_ADDR:  tgt = (dummy_n != 6'd0) ? ST_DUMMY : ST_DATA;
			default:  tgt = ST_DATA;
		endcase
		case (tgt)
			ST_CMD:
			begin
				ld_sr  = {opcode_of(mode_reg), 24'h00_0000};
				ld_w   = quad_cmd_reg ? 3'd4 : 3'd1; // RQ5
				ld_cnt = quad_cmd_reg ? 6'd2 : 6'd8;
				ld_oe  = quad_cmd_reg ? 4'hF : 4'h1;
			end
			ST_ADDR:
			begin
				ld_sr  = wide_addr_reg ? addr_reg : {addr_reg[23:0], 8'h00}; // RQ4 RQ17
				ld_w   = addr_w;
				ld_cnt = addr_n;
				ld_oe  = lane_mask(addr_w);
			end
			ST_DUMMY:
			begin
				ld_w   = addr_w;
				ld_cnt = dummy_n;
				// Quad I/O drives all-zero nibbles, which never toggle against each other
				ld_oe  = (mode_reg == MODE_QUAD_IO_READ) ? 4'hF : (addr_w == 3'd1) ? 4'h1 : 4'h0; // RQ16
			end
			default:
			begin
				ld_w   = data_w;
				ld_cnt = per_byte;
				ld_oe  = 4'h0;
			end
		endcase
	end

	// Command sequencer
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_reg     <= ST_IDLE;
			out_sr_reg    <= 32'h0000_0000;
			io_out_reg    <= 4'h0;
			io_oe_reg     <= 4'h0;
			width_reg     <= 3'd1;
			clk_left_reg  <= 6'd0;
			byte_left_reg <= 16'h0000;
			rx_sr_reg     <= 8'h00;
			dummy_idx_reg <= 4'h0;
		end
		else if ((state_reg == ST_DATA) && abort_req)
		begin
			state_reg    <= ST_DONE; // RQ6
			clk_left_reg <= 6'(CS_HIGH_CYC);
		end
		else if (enter)
		begin
			state_reg     <= tgt;
			out_sr_reg    <= ld_sr;
			io_out_reg    <= lanes_of(ld_sr, ld_w);
			width_reg     <= ld_w;
			clk_left_reg  <= ld_cnt;
			io_oe_reg     <= ld_oe;
			dummy_idx_reg <= 4'h0;
			if (state_reg == ST_LOAD)
				byte_left_reg <= len_reg;
		end
		else if ((state_reg == ST_IDLE) && go)
			state_reg <= ST_LOAD;
		else if (hdr && fall)
		begin
			// New bits go out on the falling edge, ahead of the next rise
			out_sr_reg    <= sh_sr; // RQ1
			io_out_reg    <= lanes_of(sh_sr, width_reg);
			clk_left_reg  <= clk_left_reg - 6'd1;
			dummy_idx_reg <= dummy_idx_reg + 4'h1;
			if ((state_reg == ST_DUMMY) && (mode_reg == MODE_QUAD_IO_READ) && (dummy_idx_reg == 4'h1))
				io_oe_reg <= 4'h0; // RQ16
		end
		else if ((state_reg == ST_DATA) && fall)
		begin
			rx_sr_reg <= rx_next; // RQ1
			if (clk_left_reg != 6'd1)
				clk_left_reg <= clk_left_reg - 6'd1;
			else if ((len_reg != 16'h0000) && (byte_left_reg == 16'h0001))
			begin
				state_reg    <= ST_DONE;
				clk_left_reg <= 6'(CS_HIGH_CYC);
			end
			else
			begin
				clk_left_reg  <= per_byte;
				byte_left_reg <= byte_left_reg - 16'h0001;
			end
		end
		else if (state_reg == ST_DONE)
		begin
			io_oe_reg  <= 4'h0;
			io_out_reg <= 4'h0;
			if (clk_left_reg <= 6'd1)
				state_reg <= ST_IDLE;
			else
				clk_left_reg <= clk_left_reg - 6'd1;
		end
	end

	// Divider count
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			div_reg <= '0;
		else if (!run || tick)
			div_reg <= '0;
		else
			div_reg <= div_reg + DIV_W'(1);
	end

	// Serial clock and chip select follow the state one cycle later
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sclk_reg <= 1'b0;
			cs_b_reg <= 1'b1;
		end
		else
		begin
			cs_b_reg <= !active; // RQ5 RQ6
			if (!active)
				sclk_reg <= 1'b0;
			else if (tick)
				sclk_reg <= !sclk_reg;
		end
	end

	// Two-stage synchroniser on the lanes
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			io_meta_reg <= 4'h0;
			io_sync_reg <= 4'h0;
		end
		else
		begin
			io_meta_reg <= io_in;
			io_sync_reg <= io_meta_reg;
		end
	end

	// Command setup registers, frozen while a command runs
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			mode_reg       <= CTRL_RESET[CTRL_MODE_LO +: 3];
			wide_addr_reg  <= CTRL_RESET[CTRL_WIDE];
			quad_cmd_reg   <= CTRL_RESET[CTRL_QUAD_CMD];
			dummy_code_reg <= CTRL_RESET[CTRL_DUMMY_LO +: 2];
			quad_en_reg    <= CTRL_RESET[CTRL_QUAD_EN];
			len_reg        <= CTRL_RESET[CTRL_LEN_LO +: 16];
			addr_reg       <= 32'h0000_0000;
		end
		else if (!busy)
		begin
			if (ctrl_wr)
			begin
				mode_reg       <= new_mode;
				wide_addr_reg  <= apb_req.pwdata[CTRL_WIDE];
				quad_cmd_reg   <= apb_req.pwdata[CTRL_QUAD_CMD];
				dummy_code_reg <= apb_req.pwdata[CTRL_DUMMY_LO +: 2];
				quad_en_reg    <= apb_req.pwdata[CTRL_QUAD_EN];
				len_reg        <= apb_req.pwdata[CTRL_LEN_LO +: 16];
			end
			if (wr && (apb_req.paddr == ADDR_OFS))
				addr_reg <= apb_req.pwdata;
		end
	end

	// Received byte and sticky flags; a new event beats a clear in the same cycle
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			data_reg     <= 8'h00;
			rx_valid_reg <= 1'b0;
			refused_reg  <= 1'b0;
		end
		else
		begin
			if (byte_done)
				data_reg <= rx_next;
			if (byte_done)
				rx_valid_reg <= 1'b1;
			else if (rd && (apb_req.paddr == DATA_OFS))
				rx_valid_reg <= 1'b0;
			if (bad_start)
				refused_reg <= 1'b1; // RQ12
			else if (wr && (apb_req.paddr == STAT_OFS) && apb_req.pwdata[STAT_REFUSED])
				refused_reg <= 1'b0;
		end
	end

	// Read mux; unmapped offsets answer with an error
	always_comb
	begin
		apb_rsp.prdata  = 32'h0000_0000;
		apb_rsp.pready  = 1'b1;
		apb_rsp.pslverr = 1'b0;
		if (apb_req.paddr == CTRL_OFS)
			apb_rsp.prdata = {len_reg, 7'h00, quad_en_reg, dummy_code_reg, quad_cmd_reg, wide_addr_reg, mode_reg, 1'b0};
		else if (apb_req.paddr == ADDR_OFS)
			apb_rsp.prdata = addr_reg;
		else if (apb_req.paddr == STAT_OFS)
			apb_rsp.prdata = {29'h0000_0000, refused_reg, rx_valid_reg, busy};
		else if (apb_req.paddr == DATA_OFS)
			apb_rsp.prdata = {24'h00_0000, data_reg};
		else
			apb_rsp.pslverr = apb_req.psel && apb_req.penable;
	end

	assign pins = '{cs_b: cs_b_reg, sclk: sclk_reg, io_out: io_out_reg, io_oe: io_oe_reg};

	// Rises seen in the current phase, read only by the checks below
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			rise_cnt_reg <= 6'd0;
		else if (enter || !active)
			rise_cnt_reg <= 6'd0;
		else if (rise)
			rise_cnt_reg <= rise_cnt_reg + 6'd1;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	property p_lane_stable;
		$rose(sclk_reg) |-> $stable(io_out_reg) && $stable(io_oe_reg);
	endproperty
	a_lane_stable: assert property (p_lane_stable) else $error("lanes changed at sclk rise"); // RQ1

	property p_cmd_lane;
		(state_reg == ST_CMD) && !quad_cmd_reg |-> (io_oe_reg == 4'h1);
	endproperty
	a_cmd_lane: assert property (p_cmd_lane) else $error("opcode not on lane zero"); // RQ5

	property p_addr_len;
		(state_reg == ST_ADDR) && enter |-> rise_cnt_reg == ((mode_reg == MODE_QUAD_IO_READ) ? (wide_addr_reg ? 6'd8 : 6'd6) :
			(mode_reg == MODE_DUAL_IO_READ) ? (wide_addr_reg ? 6'd16 : 6'd12) : (wide_addr_reg ? 6'd32 : 6'd24));
	endproperty
	a_addr_len: assert property (p_addr_len) else $error("address phase length wrong"); // RQ17

	property p_fast_dummy;
		(state_reg == ST_DUMMY) && enter && (mode_reg != MODE_DUAL_IO_READ) && (mode_reg != MODE_QUAD_IO_READ)
			|-> (rise_cnt_reg == 6'd8);
	endproperty
	a_fast_dummy: assert property (p_fast_dummy) else $error("single-lane dummy count wrong"); // RQ8

	property p_dio_dummy;
		(state_reg == ST_DUMMY) && enter && (mode_reg == MODE_DUAL_IO_READ)
			|-> (rise_cnt_reg == (dummy_code_reg[0] ? 6'd8 : 6'd4));
	endproperty
	a_dio_dummy: assert property (p_dio_dummy) else $error("dual I/O dummy count wrong"); // RQ11

	property p_qio_dummy;
		(state_reg == ST_DUMMY) && enter && (mode_reg == MODE_QUAD_IO_READ) && (dummy_code_reg == 2'd0)
			|-> (rise_cnt_reg == 6'd6);
	endproperty
	a_qio_dummy: assert property (p_qio_dummy) else $error("quad I/O dummy count wrong"); // RQ14

	property p_qio_drive;
		(state_reg == ST_DUMMY) && (mode_reg == MODE_QUAD_IO_READ) && (rise_cnt_reg < 6'd2)
			|-> (io_oe_reg == 4'hF) && (io_out_reg == 4'h0);
	endproperty
	a_qio_drive: assert property (p_qio_drive) else $error("quad dummy lanes not driven"); // RQ16

	property p_abort;
		(state_reg == ST_DATA) && abort_req |-> ##2 cs_b_reg && !sclk_reg;
	endproperty
	a_abort: assert property (p_abort) else $error("abort did not deselect"); // RQ6

	property p_quad_refuse;
		start_req && new_quad && !apb_req.pwdata[CTRL_QUAD_EN] |=> refused_reg && (state_reg != ST_LOAD);
	endproperty
	a_quad_refuse: assert property (p_quad_refuse) else $error("quad read started without enable"); // RQ12

	property p_data_float;
		(state_reg == ST_DATA) |-> (io_oe_reg == 4'h0);
	endproperty
	a_data_float: assert property (p_data_float) else $error("host drives lanes in data phase"); // RQ10 RQ13
endmodule : flash_read_host

/* File: testbench/flash_dev_model.sv */
// Purpose: behavioural serial flash that answers the six read commands
// Assumes: sclk idles low between frames; the board pulls every lane up
// Notes: array content is a pattern of the address, so nothing is stored
`timescale 1ns/10ps
module flash_dev_model
#(
	parameter logic [31:0] ARRAY_TOP = 32'h03FF_FFFF
)
(
	// Flash pins
	input  wire logic       cs_b,
	input  wire logic       sclk,
	inout  wire logic [3:0] io,
	// Configuration and status straps
	input  wire logic [1:0] dummy_code,
	input  wire logic       wide_address_flag,
	input  wire logic       quad_enable_bit,
	input  wire logic       quad_command_mode,
	input  wire logic       wip,
	// Host fault flag
	output logic            toggle_seen
);
	logic [3:0] dout;
	logic [3:0] oe;
	// Lanes float unless this side drives them
	for (genvar g = 0; g < 4; g++)
	begin : g_lane
		assign io[g] = oe[g] ? dout[g] : 1'bz;
	end
	initial
	begin
		oe = 4'h0;
		dout = 4'h0;
		toggle_seen = 1'b0;
	end
	function automatic logic [7:0] byte_at(input logic [31:0] a);
		byte_at = a[7:0] ^ a[15:8] ^ a[23:16] ^ a[31:24] ^ 8'hA5;
	endfunction : byte_at
	// Header bits are taken on rising sclk, top lane holds the top bit
	task automatic take(input int w, input int n, output logic [31:0] v);
		v = 32'h0;
		repeat (n)
		begin
			@(posedge sclk);
			v = (v << w) | (32'(io) & ((32'h1 << w) - 1));
		end
	endtask : take
	// One command: opcode, address, dummies, then an endless byte stream
	task automatic serve;
		logic [31:0] v;
		logic [31:0] a;
		logic [7:0]  b;
		int          aw;
		int          dw;
		int          dl;
		take(quad_command_mode ? 4 : 1, quad_command_mode ? 2 : 8, v);
		dw = (v[7:0] == 8'h3B || v[7:0] == 8'hBB) ? 2 : (v[7:0] == 8'h6B || v[7:0] == 8'hEB) ? 4 : 1;
		aw = (v[7:0] == 8'hBB) ? 2 : (v[7:0] == 8'hEB) ? 4 : 1;
		dl = (v[7:0] == 8'h03) ? 0 : (v[7:0] == 8'hBB) ? (dummy_code[0] ? 8 : 4) : 8;
		if (v[7:0] == 8'hEB)
			dl = (dummy_code == 2'd0) ? 6 : (dummy_code == 2'd1) ? 4 : (dummy_code == 2'd2) ? 8 : 10;
		// A busy array or unknown opcode leaves the lanes alone
		if (wip || !(v[7:0] inside {8'h03, 8'h0B, 8'h3B, 8'hBB, 8'h6B, 8'hEB}) || (dw == 4 && !quad_enable_bit))
			return;
		take(aw, (wide_address_flag ? 32 : 24) / aw, a);
		if (aw == 4 && !quad_command_mode)
		begin
			take(4, 2, v);
			if (v[7:4] == ~v[3:0])
				toggle_seen = 1'b1;
			dl = dl - 2;
		end
		repeat (dl) @(posedge sclk);
		forever
		begin
			b = byte_at(a & ARRAY_TOP);
			for (int k = 8 / dw - 1; k >= 0; k--)
			begin
				@(negedge sclk);
				oe <= (dw == 1) ? 4'h2 : 4'((1 << dw) - 1);
				dout <= (dw == 1) ? {2'b00, b[k], 1'b0} : 4'((b >> (k * dw)) & ((1 << dw) - 1));
			end
			a = (a + 1) & ARRAY_TOP;
		end
	endtask : serve
	// Raising chip select cuts the command off wherever it stands
	always @(negedge cs_b)
	begin
		fork
			serve;
			@(posedge cs_b);
		join_any
		disable fork;
		oe <= 4'h0;
	end
endmodule : flash_dev_model

/* File: testbench/flash_read_host_tb.sv */
// Purpose: self-checking bench of the flash read host over APB
// Assumes: pull-ups on all four lanes; flash straps follow CTRL fields, except quad enable, which is tied high
// Notes: each run reads three bytes so address steps and wrap show; the aborted stream reads two
`timescale 1ns/10ps
module flash_read_host_tb
	import flash_read_pkg::*;
();
	localparam logic [31:0] TOP = 32'h03FF_FFFF;
	logic        sys_clk = 1'b0;
	logic        rst_b = 1'b0;
	apb_req_type apb_req = '0;
	apb_rsp_type apb_rsp;
	pin_out_type pins;
	tri1  [3:0]  lane;
	logic [1:0]  dc_s = 2'd0;
	logic        wide_s = 1'b0;
	logic        qcm_s = 1'b0;
	logic        wip_s = 1'b0;
	logic        toggle_seen;
	logic [31:0] rq;
	logic        re;
	int          err_count = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	// Host side of each lane, resolved against the flash and pull-up
	for (genvar g = 0; g < 4; g++)
	begin : g_host
		assign lane[g] = pins.io_oe[g] ? pins.io_out[g] : 1'bz;
	end
	flash_read_host i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .apb_req(apb_req), .apb_rsp(apb_rsp),
		.pins(pins), .io_in(lane));
	flash_dev_model #(.ARRAY_TOP(TOP)) i_flash (.cs_b(pins.cs_b), .sclk(pins.sclk), .io(lane),
		.dummy_code(dc_s), .wide_address_flag(wide_s), .quad_enable_bit(1'b1),
		.quad_command_mode(qcm_s), .wip(wip_s), .toggle_seen(toggle_seen));
	always #50 sys_clk = ~sys_clk;
	// Hang guard, well above the longest expected run
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			err_count++;
			results;
		end
	end
	task automatic results;
		if (err_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results
	task automatic check(input string n, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask : check
	// Setup cycle, then access held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge sys_clk);
		apb_req.penable <= 1'b1;
		@(posedge sys_clk);
		while (apb_rsp.pready !== 1'b1)
			@(posedge sys_clk);
		rq = apb_rsp.prdata;
		re = apb_rsp.pslverr;
		apb_req <= '0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0000_0000);
	endtask : rd
	function automatic logic [7:0] byte_at(input logic [31:0] a);
		byte_at = a[7:0] ^ a[15:8] ^ a[23:16] ^ a[31:24] ^ 8'hA5;
	endfunction : byte_at
	function automatic logic [31:0] ctrl(input logic [2:0] m, input logic [1:0] dc, input logic w,
		input logic qc, input logic qe, input logic [15:0] len);
		ctrl = (32'(len) << CTRL_LEN_LO) | (32'(qe) << CTRL_QUAD_EN) | (32'(dc) << CTRL_DUMMY_LO)
			| (32'(qc) << CTRL_QUAD_CMD) | (32'(w) << CTRL_WIDE) | (32'(m) << CTRL_MODE_LO) | (32'h1 << CTRL_START);
	endfunction : ctrl
	// Bounded wait on one status bit
	task automatic poll(input int b, input logic v);
		for (int i = 0; i < 500; i++)
		begin
			rd(STAT_OFS);
			if (rq[b] === v)
				return;
		end
		check("status poll", 32'(v), 32'(rq[b]));
	endtask : poll
	task automatic get_bytes(input logic [31:0] a, input int n);
		for (int i = 0; i < n; i++)
		begin
			poll(STAT_VALID, 1'b1);
			rd(DATA_OFS);
			check("data byte", wip_s ? 32'h0000_00FF : 32'(byte_at(a)), 32'(rq[7:0]));
			a = (a + 1) & TOP;
		end
	endtask : get_bytes
	task automatic run(input logic [2:0] m, input logic [1:0] dc, input logic w, input logic qc, input logic [31:0] a);
		dc_s = dc;
		wide_s = w;
		qcm_s = qc;
		wr(ADDR_OFS, a);
		wr(CTRL_OFS, ctrl(m, dc, w, qc, 1'b1, 16'd3));
		get_bytes(w ? a : a & 32'h00FF_FFFF, 3);
		poll(STAT_BUSY, 1'b0);
		check("chip select", 32'h0000_0001, 32'(pins.cs_b));
	endtask : run
	// Main sequence
	initial
	begin
		repeat (6) @(posedge sys_clk);
		check("reset pins", 32'h0000_0020, {26'h0, pins.cs_b, pins.sclk, pins.io_oe});
		rst_b <= 1'b1;
		rd(CTRL_OFS);
		check("ctrl reset", CTRL_RESET, rq);
		rd(STAT_OFS);
		check("stat reset", 32'h0000_0000, rq);
		rd(8'h10);
		check("unmapped error", 32'h0000_0001, 32'(re));
		for (int m = 0; m < 6; m++)
			run(3'(m), 2'(m), m[0], 1'b0, m[0] ? TOP - 1 : 32'h5512_3456);
		run(MODE_DUAL_IO_READ, 2'd0, 1'b0, 1'b0, 32'h0000_0100);
		run(MODE_QUAD_IO_READ, 2'd0, 1'b0, 1'b0, 32'h00AB_CDEF);
		run(MODE_QUAD_IO_READ, 2'd3, 1'b1, 1'b1, TOP - 1);
		wip_s = 1'b1;
		run(MODE_READ, 2'd0, 1'b0, 1'b0, 32'h0000_0200);
		wip_s = 1'b0;
		// Endless stream cut short by abort in the data phase
		wr(ADDR_OFS, 32'h0000_0040);
		wr(CTRL_OFS, ctrl(MODE_DUAL_OUTPUT_READ, 2'd0, 1'b0, 1'b0, 1'b1, 16'd0));
		get_bytes(32'h0000_0040, 2);
		wr(CTRL_OFS, 32'h1 << CTRL_ABORT);
		repeat (3) @(posedge sys_clk);
		check("abort pins", 32'h0000_001F, {27'h0, pins.cs_b, lane});
		rd(DATA_OFS);
		poll(STAT_BUSY, 1'b0);
		// Quad read without confirmed quad enable must be refused
		wr(CTRL_OFS, ctrl(MODE_QUAD_OUTPUT_READ, 2'd0, 1'b0, 1'b0, 1'b0, 16'd1));
		rd(STAT_OFS);
		check("refused", 32'h0000_0004, rq & 32'h0000_0007);
		wr(STAT_OFS, 32'h1 << STAT_REFUSED);
		rd(STAT_OFS);
		check("refused clear", 32'h0000_0000, rq & 32'h0000_0007);
		// Quad command framing is only legal with quad I/O reads
		wr(CTRL_OFS, ctrl(MODE_FAST_READ, 2'd0, 1'b0, 1'b1, 1'b1, 16'd1));
		rd(STAT_OFS);
		check("framing refused", 32'h0000_0004, rq & 32'h0000_0007);
		wr(STAT_OFS, 32'h1 << STAT_REFUSED);
		// An undefined read kind is refused as well
		wr(CTRL_OFS, ctrl(3'd7, 2'd0, 1'b0, 1'b0, 1'b1, 16'd1));
		rd(STAT_OFS);
		check("kind refused", 32'h0000_0004, rq & 32'h0000_0007);
		check("dummy pattern", 32'h0000_0000, 32'(toggle_seen));
		results;
	end
endmodule : flash_read_host_tb
